/* program_flash_self_write_ctrl.sv */
// Program flash controller with table access, unlock guard and timed write/erase
`timescale 1ns/1ps

// Functional notes
// [RULE1] Program address is 21 bits, 2 Mbyte
// [RULE2] Unimplemented addresses read as all zeros
// [RULE3] Vectors at 0000h, 0008h and 0018h
// [RULE4] Flash size parameter: 4 or 8 Kbytes
// [RULE5] Each table read returns one byte
// [RULE6] Write commits 8-byte block at once
// [RULE7] Erase clears 64-byte block at once
// [RULE8] No whole-array erase from user code
// [RULE9] Fetch stalls during write or erase
// [RULE10] Internal timer ends each write or erase
// [RULE11] Any data storable; core decodes invalid as no-op
// [RULE12] 16-bit program words via 8-bit latch
// [RULE13] Table write fills holding registers only
// [RULE14] Table access is byte addressed
// [RULE15] Unlock port stores nothing, reads zero
// [RULE16] Space select: program flash or data memory
// [RULE17] Config select overrides space select
// [RULE18] Erase select makes go start erase
// [RULE19] Program enable required, cleared at power-up
// [RULE20] Fault set at go, cleared at completion
// [RULE21] Go set by software, cleared by hardware
// [RULE22] Done flag bit 4, software clears
// [RULE23] Table pointer 21 bits in three bytes
// [RULE24] Start only after unlock sequence
// [RULE25] Unlock: 55h, AAh, then go, consecutive
// [RULE26] Commit to aligned block at pointer
module program_flash_self_write_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int FLASH_BYTES = FLASH_BYTES_SMALL,
	parameter int PROG_CYC    = PROG_CYCLES
) (
	// Clock and resets
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        por,
	// AXI4-Lite write address and data
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Instruction fetch
	input  wire logic        fetch_req,
	input  wire logic [1:0]  fetch_kind,
	input  wire logic [20:0] fetch_addr,
	output logic [15:0]      fetch_word,
	output logic             fetch_valid,
	output logic             fetch_stall
);

	// ****************************************************************
	// Parameter checks
	// ****************************************************************
	if (FLASH_BYTES != FLASH_BYTES_SMALL && FLASH_BYTES != FLASH_BYTES_LARGE) begin : g_size_chk
		$error("FLASH_BYTES must be 4096 or 8192"); // see [RULE4]
	end
	if (PROG_CYC < 1) begin : g_cyc_chk
		$error("PROG_CYC must be at least 1");
	end

	localparam logic [20:0] FLASH_LIMIT = 21'(FLASH_BYTES);
	localparam logic [31:0] TIMER_LOAD  = 32'(PROG_CYC - 1);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [FLASH_BYTES-1:0][7:0] mem;
		logic [WRITE_BLOCK_BYTES-1:0][7:0] hold;
		logic [20:0] ptr;
		logic [7:0]  latch;
		logic        space_sel;
		logic        cfg_sel;
		logic        erase_sel;
		logic        prog_en;
		logic        prog_go;
		logic        prog_fault;
		logic        done_flag;
		unlock_t     unlock;
		op_t         op;
		logic        op_erase;
		logic        op_flash;
		logic [20:0] op_addr;
		logic [31:0] timer;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] fword;
		logic        fvalid;
		logic        stall;
	} state_t;

	state_t q;
	state_t d;

	// Word read from the array; holes above the implemented size read zero
	function automatic logic [15:0] word_at(input state_t s, input logic [20:0] a);
		logic [20:0] base;
		base = {a[20:1], 1'b0};
		if (base < FLASH_LIMIT) begin
			word_at = {s.mem[base + 21'h0_0001], s.mem[base]}; // see [RULE12]
		end else begin
			word_at = 16'h0000; // see [RULE2]
		end
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic        wr_take;
		logic        rd_take;
		logic        mapped;
		logic [7:0]  wb;
		logic [7:0]  ofs;
		logic        flash_tgt;
		logic [20:0] base;
		logic [20:0] idx;
		logic [20:0] fa;
		wr_take   = 1'b0;
		rd_take   = 1'b0;
		mapped    = 1'b0;
		wb        = s_axi_wdata[7:0];
		ofs       = 8'h00;
		flash_tgt = 1'b0;
		base      = 21'h0_0000;
		idx       = 21'h0_0000;
		fa        = 21'h0_0000;
		d         = q;
		d.awready = 1'b0;
		d.wready  = 1'b0;
		d.arready = 1'b0;
		d.fvalid  = 1'b0;

		// Config space wins over space select
		flash_tgt = q.space_sel && !q.cfg_sel; // see [RULE16] see [RULE17]

		// ************************************************************
		// Register writes
		// ************************************************************
		wr_take = s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid;
		if (wr_take) begin
			d.awready = 1'b1;
			d.wready  = 1'b1;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.awready) begin
			ofs    = s_axi_awaddr[7:0];
			mapped = (s_axi_awaddr[31:8] == 24'h00_0000) && (ofs <= OFS_TABLE_OP)
				&& (ofs[1:0] == 2'b00);
			d.bvalid = 1'b1;
			d.bresp  = mapped ? RESP_OKAY : RESP_SLVERR;
			// Any other write between keys and go breaks the sequence
			if (ofs != OFS_UNLOCK) begin
				d.unlock = UNLOCK_IDLE; // see [RULE25]
			end
			if (mapped && s_axi_wstrb[0]) begin
				unique case (ofs)
					OFS_PTR_LOW: begin
						d.ptr[7:0] = wb; // see [RULE23]
					end
					OFS_PTR_HIGH: begin
						d.ptr[15:8] = wb;
					end
					OFS_PTR_UP: begin
						d.ptr[20:16] = wb[4:0]; // see [RULE1]
					end
					OFS_LATCH: begin
						d.latch = wb;
					end
					OFS_UNLOCK: begin
						// Only the key tracker sees this value
						if (wb == UNLOCK_KEY_FIRST) begin
							d.unlock = UNLOCK_FIRST_SEEN; // see [RULE15]
						end else if (wb == UNLOCK_KEY_SECOND && q.unlock == UNLOCK_FIRST_SEEN) begin
							d.unlock = UNLOCK_ARMED;
						end else begin
							d.unlock = UNLOCK_IDLE;
						end
					end
					OFS_CONTROL: begin
						d.space_sel = wb[BIT_SPACE_SELECT];
						d.cfg_sel   = wb[BIT_CONFIG_SELECT];
						d.erase_sel = wb[BIT_ERASE_SELECT];
						d.prog_en   = wb[BIT_PROGRAM_EN];
						// Go can only be set; writing zero leaves it alone
						if (wb[BIT_PROGRAM_GO] && !q.prog_go && q.op == OP_IDLE
							&& q.unlock == UNLOCK_ARMED && wb[BIT_PROGRAM_EN]) begin // see [RULE21] see [RULE24] see [RULE19]
							d.prog_go    = 1'b1;
							d.prog_fault = 1'b1; // see [RULE20]
							d.op         = OP_BUSY;
							d.op_erase   = wb[BIT_ERASE_SELECT]; // see [RULE18]
							d.op_flash   = wb[BIT_SPACE_SELECT] && !wb[BIT_CONFIG_SELECT];
							d.op_addr    = q.ptr;
							d.timer      = TIMER_LOAD; // see [RULE10]
							d.stall      = 1'b1; // see [RULE9]
						end
					end
					OFS_FLAGS_B: begin
						if (!wb[BIT_NVM_DONE]) begin
							d.done_flag = 1'b0; // see [RULE22]
						end
					end
					OFS_TABLE_OP: begin
						if (q.op == OP_IDLE) begin
							if (wb[BIT_OP_READ]) begin
								// One byte per read, any byte address
								if (flash_tgt && q.ptr < FLASH_LIMIT) begin
									d.latch = q.mem[q.ptr]; // see [RULE5] see [RULE14]
								end else begin
									d.latch = 8'h00; // see [RULE2]
								end
							end else if (wb[BIT_OP_WRITE] && flash_tgt) begin
								d.hold[q.ptr[2:0]] = q.latch; // see [RULE13]
							end
							if (wb[BIT_OP_POST_INC] && (wb[BIT_OP_READ] || wb[BIT_OP_WRITE])) begin
								d.ptr = q.ptr + 21'h0_0001;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end

		// ************************************************************
		// Register reads
		// ************************************************************
		rd_take = s_axi_arvalid && !q.arready && !q.rvalid;
		if (rd_take) begin
			d.arready = 1'b1;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (q.arready) begin
			d.rvalid = 1'b1;
			d.rresp  = RESP_OKAY;
			d.rdata  = 32'h0000_0000;
			if (s_axi_araddr[31:8] != 24'h00_0000 || s_axi_araddr[1:0] != 2'b00) begin
				d.rresp = RESP_SLVERR;
			end else begin
				unique case (s_axi_araddr[7:0])
					OFS_PTR_LOW:  d.rdata[7:0] = q.ptr[7:0];
					OFS_PTR_HIGH: d.rdata[7:0] = q.ptr[15:8];
					OFS_PTR_UP:   d.rdata[4:0] = q.ptr[20:16];
					OFS_LATCH:    d.rdata[7:0] = q.latch;
					OFS_CONTROL: begin
						d.rdata[BIT_SPACE_SELECT]  = q.space_sel;
						d.rdata[BIT_CONFIG_SELECT] = q.cfg_sel;
						d.rdata[BIT_ERASE_SELECT]  = q.erase_sel;
						d.rdata[BIT_PROGRAM_FAULT] = q.prog_fault;
						d.rdata[BIT_PROGRAM_EN]    = q.prog_en;
						d.rdata[BIT_PROGRAM_GO]    = q.prog_go;
					end
					OFS_UNLOCK:   d.rdata = 32'h0000_0000; // see [RULE15]
					OFS_FLAGS_B:  d.rdata[BIT_NVM_DONE] = q.done_flag;
					OFS_TABLE_OP: d.rdata = 32'h0000_0000;
					default:      d.rresp = RESP_SLVERR;
				endcase
			end
		end

		// ************************************************************
		// Timed write or erase
		// ************************************************************
		if (q.op == OP_BUSY) begin
			if (q.timer != 32'h0000_0000) begin
				d.timer = q.timer - 32'h0000_0001;
			end else begin
				if (q.op_flash && q.op_erase) begin
					// Block erase only; outside por no path clears the whole array
					base = {q.op_addr[20:6], 6'h00}; // see [RULE8] see [RULE26]
					for (int i = 0; i < ERASE_BLOCK_BYTES; i++) begin
						idx = base + 21'(i);
						if (idx < FLASH_LIMIT) begin
							d.mem[idx] = ERASED_BYTE; // see [RULE7]
						end
					end
				end else if (q.op_flash) begin
					base = {q.op_addr[20:3], 3'h0}; // see [RULE26]
					for (int i = 0; i < WRITE_BLOCK_BYTES; i++) begin
						idx = base + 21'(i);
						if (idx < FLASH_LIMIT) begin
							d.mem[idx] = q.hold[i]; // see [RULE6] see [RULE11]
						end
					end
				end
				if (!q.op_erase) begin
					for (int i = 0; i < WRITE_BLOCK_BYTES; i++) begin
						d.hold[i] = ERASED_BYTE;
					end
				end
				d.op         = OP_IDLE;
				d.prog_go    = 1'b0; // see [RULE21]
				d.prog_fault = 1'b0; // see [RULE20]
				d.done_flag  = 1'b1; // see [RULE22]
				d.stall      = 1'b0; // see [RULE9]
			end
		end

		// ************************************************************
		// Instruction fetch
		// ************************************************************
		if (fetch_req && q.op == OP_IDLE) begin // see [RULE9]
			unique case (fetch_kind_t'(fetch_kind))
				FETCH_NORMAL:    fa = fetch_addr;
				FETCH_RESET_VEC: fa = RESET_VECTOR; // see [RULE3]
				FETCH_HIGH_VEC:  fa = IRQ_HIGH_VECTOR;
				FETCH_LOW_VEC:   fa = IRQ_LOW_VECTOR;
			endcase
			d.fword  = word_at(q, fa);
			d.fvalid = 1'b1;
		end

		// ************************************************************
		// Resets
		// ************************************************************
		if (reset || por) begin
			d.hold       = '1;
			d.ptr        = 21'h0_0000;
			d.latch      = 8'h00;
			d.space_sel  = 1'b0;
			d.cfg_sel    = 1'b0;
			d.erase_sel  = 1'b0;
			d.prog_en    = 1'b0; // see [RULE19]
			d.prog_go    = 1'b0;
			d.done_flag  = 1'b0;
			d.unlock     = UNLOCK_IDLE;
			d.op         = OP_IDLE;
			d.op_erase   = 1'b0;
			d.op_flash   = 1'b0;
			d.op_addr    = 21'h0_0000;
			d.timer      = 32'h0000_0000;
			d.awready    = 1'b0;
			d.wready     = 1'b0;
			d.bvalid     = 1'b0;
			d.bresp      = RESP_OKAY;
			d.arready    = 1'b0;
			d.rvalid     = 1'b0;
			d.rdata      = 32'h0000_0000;
			d.rresp      = RESP_OKAY;
			d.fword      = 16'h0000;
			d.fvalid     = 1'b0;
			d.stall      = 1'b0;
			// A device reset keeps the array and marks a cut-short operation
			d.prog_fault = q.prog_fault || (q.op == OP_BUSY); // see [RULE20]
			if (por) begin
				d.mem        = {FLASH_BYTES{ERASED_BYTE}};
				d.prog_fault = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rvalid  = q.rvalid;
	assign fetch_word    = q.fword;
	assign fetch_valid   = q.fvalid;
	assign fetch_stall   = q.stall;

endmodule // program_flash_self_write_ctrl

/* flash_ctrl_pkg.sv */
// Shared constants and types for the program flash self-write controller
package flash_ctrl_pkg;

	// ****************************************************************
	// Address space and vectors
	// ****************************************************************
	localparam int          PC_WIDTH          = 21;
	localparam int          FLASH_BYTES_SMALL = 4096;
	localparam int          FLASH_BYTES_LARGE = 8192;
	localparam logic [20:0] RESET_VECTOR      = 21'h0_0000;
	localparam logic [20:0] IRQ_HIGH_VECTOR   = 21'h0_0008;
	localparam logic [20:0] IRQ_LOW_VECTOR    = 21'h0_0018;
	localparam int          WRITE_BLOCK_BYTES = 8;
	localparam int          ERASE_BLOCK_BYTES = 64;
	localparam logic [7:0]  ERASED_BYTE       = 8'hFF;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_PTR_LOW  = 8'h00;
	localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
	localparam logic [7:0] OFS_PTR_UP   = 8'h08;
	localparam logic [7:0] OFS_LATCH    = 8'h0C;
	localparam logic [7:0] OFS_CONTROL  = 8'h10;
	localparam logic [7:0] OFS_UNLOCK   = 8'h14;
	localparam logic [7:0] OFS_FLAGS_B  = 8'h18;
	localparam logic [7:0] OFS_TABLE_OP = 8'h1C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_SPACE_SELECT  = 7;
	localparam int BIT_CONFIG_SELECT = 6;
	localparam int BIT_ERASE_SELECT  = 4;
	localparam int BIT_PROGRAM_FAULT = 3;
	localparam int BIT_PROGRAM_EN    = 2;
	localparam int BIT_PROGRAM_GO    = 1;
	localparam int BIT_NVM_DONE      = 4;
	localparam int BIT_OP_READ       = 0;
	localparam int BIT_OP_WRITE      = 1;
	localparam int BIT_OP_POST_INC   = 2;

	// ****************************************************************
	// Unlock keys, responses, timing
	// ****************************************************************
	localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
	localparam logic [1:0] RESP_OKAY         = 2'h0;
	localparam logic [1:0] RESP_SLVERR       = 2'h2;
	localparam int         CLK_PERIOD_NS     = 4;
	localparam int         PROG_TIME_NS      = 2000000;
	localparam int         PROG_CYCLES       = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_FIRST_SEEN, UNLOCK_ARMED} unlock_t;
	typedef enum logic {OP_IDLE, OP_BUSY} op_t;
	typedef enum logic [1:0] {FETCH_NORMAL, FETCH_RESET_VEC, FETCH_HIGH_VEC, FETCH_LOW_VEC} fetch_kind_t;

endpackage

/* flash_ctrl_chk.sv */
// Port-level checks for the program flash self-write controller
`timescale 1ns/1ps
module flash_ctrl_chk
	import flash_ctrl_pkg::*;
#(
	parameter int FLASH_BYTES = FLASH_BYTES_SMALL,
	parameter int PROG_CYC    = PROG_CYCLES
) (
	// Clock and resets
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        por,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	// Fetch
	input wire logic        fetch_req,
	input wire logic [1:0]  fetch_kind,
	input wire logic [20:0] fetch_addr,
	input wire logic [15:0] fetch_word,
	input wire logic        fetch_valid,
	input wire logic        fetch_stall
);
	logic [31:0] stall_cnt_q;
	logic [31:0] stall_cnt_d;

	// Counts stall cycles; a counter avoids a long repetition
	always_comb stall_cnt_d = fetch_stall ? stall_cnt_q + 32'h1 : 32'h0;
	always_ff @(posedge clk) begin
		if (reset || por) stall_cnt_q <= 32'h0;
		else stall_cnt_q <= stall_cnt_d;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || por);

	// Control write cycle excluded: an operation may start on that edge
	a_fetch_answer: assert property (
		fetch_req && !fetch_stall && !s_axi_awready |=> fetch_valid)
		else $error("idle fetch not answered");
	a_stall_blocks: assert property (
		fetch_stall && $past(fetch_stall) |-> !fetch_valid)
		else $error("fetch answered while stalled");
	a_valid_cause: assert property (fetch_valid |-> $past(fetch_req))
		else $error("fetch answer without request");
	a_stall_len: assert property (
		$fell(fetch_stall) |-> stall_cnt_q == PROG_CYC)
		else $error("operation length wrong");
	a_stall_bound: assert property (
		fetch_stall |-> stall_cnt_q < PROG_CYC)
		else $error("operation overruns timer");
	a_stall_cause: assert property (
		$rose(fetch_stall) |-> $rose(s_axi_bvalid))
		else $error("operation without write");
	a_top_zero: assert property (
		fetch_req && !fetch_stall && !s_axi_awready && fetch_kind == 2'h0
		&& fetch_addr >= FLASH_BYTES |=> fetch_word == 16'h0)
		else $error("unimplemented space not zero");
	a_unlock_zero: assert property (
		s_axi_arready && s_axi_araddr == 32'(OFS_UNLOCK) |=> s_axi_rdata == 32'h0)
		else $error("unlock port not zero");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above byte");
	a_wready_pair: assert property (s_axi_wready == s_axi_awready)
		else $error("write data ready apart from address ready");

	c_op_done: cover property ($fell(fetch_stall));
	c_top_fetch: cover property (fetch_valid && fetch_word == 16'h0);
	c_unlock_read: cover property (s_axi_arready && s_axi_araddr == 32'(OFS_UNLOCK));
endmodule // flash_ctrl_chk

bind program_flash_self_write_ctrl flash_ctrl_chk #(
	.FLASH_BYTES(FLASH_BYTES),
	.PROG_CYC   (PROG_CYC)
) u_chk (.clk, .reset, .por, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .fetch_req, .fetch_kind, .fetch_addr, .fetch_word,
	.fetch_valid, .fetch_stall);

/* core_fetch_model.sv */
// Processor core model issuing instruction fetches
`timescale 1ns/1ps
module core_fetch_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Bench command
	input  wire logic        start,
	input  wire logic [1:0]  start_kind,
	input  wire logic [20:0] start_addr,
	output logic             busy,
	output logic [15:0]      word,
	// Fetch port
	output logic             fetch_req,
	output logic [1:0]       fetch_kind,
	output logic [20:0]      fetch_addr,
	input  wire logic [15:0] fetch_word,
	input  wire logic        fetch_valid
);
	always_ff @(posedge clk) begin
		if (reset) begin
			fetch_req  <= 1'b0;
			busy       <= 1'b0;
			word       <= 16'h0;
			fetch_kind <= 2'h0;
			fetch_addr <= 21'h0;
		end else if (start) begin
			fetch_req  <= 1'b1;
			busy       <= 1'b1;
			fetch_kind <= start_kind;
			fetch_addr <= start_addr;
		end else if (fetch_req) begin
			fetch_req <= 1'b0;
		end else if (busy && fetch_valid) begin
			word       <= fetch_word;
			busy       <= 1'b0;
			// Released address shows garbage, not the last value
			fetch_addr <= ~fetch_addr;
		end else if (busy) begin
			fetch_req <= 1'b1;
		end
	end
endmodule // core_fetch_model

/* program_flash_self_write_ctrl_tb.sv */
// Self-checking bench for the program flash self-write controller
`timescale 1ns/1ps
module program_flash_self_write_ctrl_tb
	import flash_ctrl_pkg::*;
;
	localparam int CYC = 20;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rexp;
		logic [1:0] resp;
	} row_t;
	logic        clk, reset, por, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, fetch_req, fetch_valid, fetch_stall, f_go, f_busy;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, fetch_kind, f_kind, rs_q;
	logic [20:0] fetch_addr, f_addr;
	logic [15:0] fetch_word, f_word;
	logic [7:0]  rd_q;
	int          failures, checks_done;
	row_t rows [8] = '{
		'{OFS_PTR_LOW,  8'h5A, 8'h5A, RESP_OKAY},
		'{OFS_PTR_HIGH, 8'hC3, 8'hC3, RESP_OKAY},
		'{OFS_PTR_UP,   8'hFF, 8'h1F, RESP_OKAY},
		'{OFS_LATCH,    8'hA5, 8'hA5, RESP_OKAY},
		'{OFS_UNLOCK,   8'h55, 8'h00, RESP_OKAY},
		'{OFS_CONTROL,  8'hFF, 8'hD4, RESP_OKAY},
		'{OFS_CONTROL,  8'h00, 8'h00, RESP_OKAY},
		'{8'h20,        8'h5A, 8'h00, RESP_SLVERR}
	};

	program_flash_self_write_ctrl #(.FLASH_BYTES(FLASH_BYTES_SMALL), .PROG_CYC(CYC)) dut (
		.clk, .reset, .por, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_kind, .fetch_addr, .fetch_word,
		.fetch_valid, .fetch_stall);
	core_fetch_model core (.clk, .reset, .start(f_go), .start_kind(f_kind), .start_addr(f_addr),
		.busy(f_busy), .word(f_word), .fetch_req, .fetch_kind, .fetch_addr, .fetch_word,
		.fetch_valid);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// *****
	// Tasks
	// *****
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Select: 0 awready, 1 bvalid, 2 arready, 3 rvalid; a lost answer counts as a mismatch
	task automatic hold(input int sel);
		int         n;
		logic [3:0] v;
		n = 0;
		v = 4'h0;
		do begin
			@(posedge clk);
			n++;
			v = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
		end while (v[sel] !== 1'b1 && n < 200);
		if (v[sel] !== 1'b1) failures++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		s_axi_awaddr  <= {24'h0, a};
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		hold(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		hold(1);
		s_axi_bready <= 1'b0;
		rs_q = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr  <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		hold(2);
		s_axi_arvalid <= 1'b0;
		hold(3);
		s_axi_rready <= 1'b0;
		rd_q = s_axi_rdata[7:0];
		rs_q = s_axi_rresp;
	endtask
	task automatic fet(input logic [1:0] k, input logic [20:0] a, input logic [15:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		f_go   <= 1'b1;
		f_kind <= k;
		f_addr <= a;
		@(posedge clk);
		f_go <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (f_busy !== 1'b0 && n < 200);
		if (f_busy !== 1'b0) failures++;
		chk("fetch_word", exp, f_word);
	endtask
	task automatic start_op(input logic [7:0] c);
		wr(OFS_UNLOCK, UNLOCK_KEY_FIRST);
		wr(OFS_UNLOCK, UNLOCK_KEY_SECOND);
		wr(OFS_CONTROL, c);
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// *****
	// Tests
	// *****
	initial begin
		failures = 0;
		checks_done = 0;
		{reset, por, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'b110000;
		{s_axi_rready, f_go, f_kind, f_addr} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		por   <= 1'b0;
		rd(OFS_CONTROL);
		chk("control", 16'h0, 16'(rd_q));
		fet(2'd1, 21'h0, 16'hFFFF);
		fet(2'd0, 21'h1F_FFFE, 16'h0);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			chk("bresp", 16'(rows[i].resp), 16'(rs_q));
			rd(rows[i].addr);
			chk("rresp", 16'(rows[i].resp), 16'(rs_q));
			chk("rdata", 16'(rows[i].rexp), 16'(rd_q));
		end
		// Holding registers only fill while program flash is the target
		wr(OFS_CONTROL, 8'h84);
		wr(OFS_PTR_UP, 8'h0);
		wr(OFS_PTR_HIGH, 8'h0);
		wr(OFS_PTR_LOW, 8'h08);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_LATCH, 8'h10 + 8'(i));
			wr(OFS_TABLE_OP, 8'h06);
		end
		// Unaligned pointer inside the block: commit must still align
		wr(OFS_PTR_LOW, 8'h0B);
		wr(OFS_TABLE_OP, 8'h01);
		rd(OFS_LATCH);
		chk("latch", 16'hFF, 16'(rd_q));
		start_op(8'h86);
		chk("stall", 16'h1, 16'(fetch_stall));
		wr(OFS_CONTROL, 8'h84);
		rd(OFS_CONTROL);
		chk("control", 16'h8E, 16'(rd_q));
		fet(2'd2, 21'h0, 16'h1110);
		rd(OFS_CONTROL);
		chk("control", 16'h84, 16'(rd_q));
		rd(OFS_FLAGS_B);
		chk("flags", 16'h10, 16'(rd_q));
		wr(OFS_FLAGS_B, 8'h0);
		rd(OFS_FLAGS_B);
		chk("flags", 16'h0, 16'(rd_q));
		fet(2'd0, 21'h0E, 16'h1716);
		fet(2'd3, 21'h0, 16'hFFFF);
		wr(OFS_PTR_LOW, 8'h0D);
		wr(OFS_TABLE_OP, 8'h01);
		rd(OFS_LATCH);
		chk("latch", 16'h15, 16'(rd_q));
		// Write with the low byte lane off must leave the latch alone
		s_axi_wstrb <= 4'h0;
		wr(OFS_LATCH, 8'h77);
		s_axi_wstrb <= 4'hF;
		rd(OFS_LATCH);
		chk("latch_nostrb", 16'h15, 16'(rd_q));
		start_op(8'h96);
		fet(2'd2, 21'h0, 16'hFFFF);
		wr(OFS_UNLOCK, UNLOCK_KEY_FIRST);
		wr(OFS_PTR_LOW, 8'h0);
		wr(OFS_UNLOCK, UNLOCK_KEY_SECOND);
		wr(OFS_CONTROL, 8'h86);
		chk("stall", 16'h0, 16'(fetch_stall));
		start_op(8'h86);
		repeat (3) @(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(OFS_CONTROL);
		chk("control", 16'h08, 16'(rd_q));
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		rd(OFS_CONTROL);
		chk("control", 16'h0, 16'(rd_q));
		// Config space wins: a table read there never sees the erased array
		wr(OFS_CONTROL, 8'hC0);
		wr(OFS_TABLE_OP, 8'h01);
		rd(OFS_LATCH);
		chk("latch_cfg", 16'h0, 16'(rd_q));
		end_sim();
	end

	initial begin
		#(4 * 5000);
		failures++;
		end_sim();
	end
endmodule // program_flash_self_write_ctrl_tb
